// [src/spss_pkg.sv]
package spss_pkg;
   // ****************************************
   // register window offsets
   // ****************************************
   localparam logic [7:0] OFS_EVENT = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_STATE = 8'h08;
   localparam logic [7:0] OFS_FORCE = 8'h0c;

   // ****************************************
   // status word field positions
   // ****************************************
   localparam int B_SOCK_YY = 31;
   localparam int B_SOCK_XX = 30;
   localparam int B_SOCK_3V3 = 29;
   localparam int B_SOCK_5V0 = 28;
   localparam int B_ZOOM = 27;
   localparam int B_RSVD_HI = 26;
   localparam int B_RSVD_LO = 14;
   localparam int B_CARD_VCC_HI = 13;
   localparam int B_CARD_VCC_LO = 10;
   localparam int B_BAD_VCC = 9;
   localparam int B_DATA_LOSS = 8;
   localparam int B_UNRECOG = 7;
   localparam int B_IRQ_READY = 6;
   localparam int B_TYPE_32 = 5;
   localparam int B_TYPE_16 = 4;
   localparam int B_POWERED = 3;
   localparam int B_DET_B = 2;
   localparam int B_DET_A = 1;
   localparam int B_STS = 0;

   // event flag positions
   localparam int E_PWR = 3;
   localparam int E_DET_B = 2;
   localparam int E_DET_A = 1;
   localparam int E_STS = 0;

   // ****************************************
   // reset values and synchroniser depth
   // ****************************************
   localparam logic [2:0] RST_SOCK_CAPS = 3'h1;
   localparam logic [3:0] RST_CARD_VCC = 4'h0;
   localparam logic [1:0] RST_DETECT = 2'h3;
   localparam logic [3:0] RST_EVENTS = 4'h0;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;
   localparam int SYNC_STAGES = 2;

   // result of one card interrogation
   typedef struct packed {
      logic [3:0] card_vcc_ok;
      logic unrecognised;
      logic is_32bit;
      logic is_16bit;
   } spss_interrog_t;

   // raw card-side pins
   typedef struct packed {
      logic detect_pin_a;
      logic detect_pin_b;
      logic card_status_change_pin;
      logic card_ready_irq_pin;
      logic bus_reset_n;
   } spss_pins_t;
endpackage

// [src/spss_sync.sv]
`timescale 1ns/10ps
module spss_sync #(
   parameter int W = 1
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] rst_val_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // reset value is a constant at the instance; only the second stage is read
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q ^ rst_val_i;
endmodule // spss_sync

// [src/spss_state.sv]
`timescale 1ns/10ps
module spss_state (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire spss_pkg::spss_pins_t pins_i,
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   input wire logic dev_ctl_5v_off_i,
   input wire logic power_mgmt_wake_i,
   input wire logic interrog_busy_i,
   input wire logic interrog_done_i,
   input wire spss_pkg::spss_interrog_t interrog_res_i,
   input wire logic socket_powered_i,
   input wire logic bad_vcc_req_i,
   input wire logic data_loss_i,
   output logic [3:0] event_flags_o
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   spss_pkg::spss_pins_t pins_s;

   // detect pins and bus reset idle high, so they come out of reset high
   spss_sync #(.W(5)) u_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .rst_val_i(5'h19),
      .d_i(pins_i ^ 5'h19),
      .q_o(pins_s)
   );

   logic ctx_clr;
   assign ctx_clr = !pins_s.bus_reset_n && !power_mgmt_wake_i;

   // ****************************************
   // status state
   // ****************************************
   logic [2:0] caps_q, caps_d;
   logic zoom_q, zoom_d;
   logic [3:0] vcc_q, vcc_d;
   logic badv_q, badv_d;
   logic loss_q, loss_d;
   logic unrec_q, unrec_d;
   logic t32_q, t32_d;
   logic t16_q, t16_d;
   logic pwr_q, pwr_d;
   logic [1:0] det_q, det_d;
   logic sts_q, sts_d;
   logic [3:0] evt_q, evt_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] word;
   logic force_wr, event_wr, rd_state;

   assign force_wr = reg_wr_i && (reg_addr_i == spss_pkg::OFS_FORCE);
   assign event_wr = reg_wr_i && (reg_addr_i == spss_pkg::OFS_EVENT);
   assign rd_state = reg_rd_i && (reg_addr_i == spss_pkg::OFS_STATE);

   always_comb begin
      caps_d = caps_q;
      zoom_d = zoom_q;
      vcc_d = vcc_q;
      badv_d = badv_q || bad_vcc_req_i;
      loss_d = loss_q || data_loss_i;
      unrec_d = unrec_q;
      t32_d = t32_q;
      t16_d = t16_q;
      pwr_d = socket_powered_i;
      det_d = det_q;
      // detect lines frozen during interrogation
      if (!interrog_busy_i) begin
         det_d = {pins_s.detect_pin_b, pins_s.detect_pin_a};
      end
      if (interrog_done_i) begin
         vcc_d = interrog_res_i.card_vcc_ok;
         t32_d = interrog_res_i.is_32bit;
         t16_d = interrog_res_i.is_16bit;
         // only a valid card releases the flag
         if (interrog_res_i.unrecognised) begin
            unrec_d = 1'b1;
         end else if (interrog_res_i.is_32bit || interrog_res_i.is_16bit) begin
            unrec_d = 1'b0;
         end
      end
      if (force_wr) begin
         caps_d = reg_wdata_i[spss_pkg::B_SOCK_YY:spss_pkg::B_SOCK_3V3];
         zoom_d = reg_wdata_i[spss_pkg::B_ZOOM];
         vcc_d = vcc_d | reg_wdata_i[spss_pkg::B_CARD_VCC_HI:spss_pkg::B_CARD_VCC_LO];
         badv_d = badv_d | reg_wdata_i[spss_pkg::B_BAD_VCC];
         loss_d = loss_d | reg_wdata_i[spss_pkg::B_DATA_LOSS];
         unrec_d = unrec_d | reg_wdata_i[spss_pkg::B_UNRECOG];
         t32_d = t32_d | reg_wdata_i[spss_pkg::B_TYPE_32];
         t16_d = t16_d | reg_wdata_i[spss_pkg::B_TYPE_16];
      end
      if (ctx_clr) begin
         zoom_d = 1'b0;
         vcc_d = spss_pkg::RST_CARD_VCC;
         badv_d = 1'b0;
         loss_d = 1'b0;
         unrec_d = 1'b0;
         t32_d = 1'b0;
         t16_d = 1'b0;
         pwr_d = 1'b0;
         det_d = spss_pkg::RST_DETECT;
      end
      sts_d = pins_s.card_status_change_pin;
   end

   // ****************************************
   // assembled word
   // ****************************************
   always_comb begin
      word = '0;
      word[spss_pkg::B_SOCK_YY:spss_pkg::B_SOCK_3V3] = caps_q;
      word[spss_pkg::B_SOCK_5V0] = !dev_ctl_5v_off_i;
      word[spss_pkg::B_ZOOM] = zoom_q;
      word[spss_pkg::B_CARD_VCC_HI:spss_pkg::B_CARD_VCC_LO] = vcc_q;
      word[spss_pkg::B_BAD_VCC] = badv_q;
      word[spss_pkg::B_DATA_LOSS] = loss_q;
      word[spss_pkg::B_UNRECOG] = unrec_q;
      word[spss_pkg::B_IRQ_READY] = pins_s.card_ready_irq_pin;
      word[spss_pkg::B_TYPE_32] = t32_q;
      word[spss_pkg::B_TYPE_16] = t16_q;
      word[spss_pkg::B_POWERED] = pwr_q;
      word[spss_pkg::B_DET_B:spss_pkg::B_DET_A] = det_q;
      word[spss_pkg::B_STS] = pins_s.card_status_change_pin;
   end

   // ****************************************
   // sticky events and read port
   // ****************************************
   logic sts_rise, sts_edge;
   assign sts_rise = sts_d && !sts_q;
   assign sts_edge = sts_d != sts_q;

   always_comb begin
      evt_d = evt_q;
      // clear first so a same-cycle event wins
      if (event_wr) begin
         evt_d = evt_d & ~reg_wdata_i[3:0];
      end
      if (force_wr) begin
         evt_d = evt_d | reg_wdata_i[3:0];
      end
      evt_d[spss_pkg::E_PWR] = evt_d[spss_pkg::E_PWR] | (pwr_d != pwr_q);
      evt_d[spss_pkg::E_DET_B] = evt_d[spss_pkg::E_DET_B] | (det_d[1] != det_q[1]);
      evt_d[spss_pkg::E_DET_A] = evt_d[spss_pkg::E_DET_A] | (det_d[0] != det_q[0]);
      // 32-bit cards flag rising edge only
      evt_d[spss_pkg::E_STS] = evt_d[spss_pkg::E_STS] | (t32_q ? sts_rise : sts_edge);
      rdata_d = spss_pkg::RST_RDATA;
      if (rd_state) begin
         rdata_d = word;
      end else if (reg_rd_i && reg_addr_i == spss_pkg::OFS_EVENT) begin
         rdata_d = {28'h0, evt_q};
      end
   end

   // writes to the status offset decode to nothing, so no state moves
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         caps_q <= spss_pkg::RST_SOCK_CAPS;
         zoom_q <= 1'b0;
         vcc_q <= spss_pkg::RST_CARD_VCC;
         badv_q <= 1'b0;
         loss_q <= 1'b0;
         unrec_q <= 1'b0;
         t32_q <= 1'b0;
         t16_q <= 1'b0;
         pwr_q <= 1'b0;
         det_q <= spss_pkg::RST_DETECT;
         sts_q <= 1'b0;
         evt_q <= spss_pkg::RST_EVENTS;
         rdata_q <= spss_pkg::RST_RDATA;
      end else begin
         caps_q <= caps_d;
         zoom_q <= zoom_d;
         vcc_q <= vcc_d;
         badv_q <= badv_d;
         loss_q <= loss_d;
         unrec_q <= unrec_d;
         t32_q <= t32_d;
         t16_q <= t16_d;
         pwr_q <= pwr_d;
         det_q <= det_d;
         sts_q <= sts_d;
         evt_q <= evt_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign event_flags_o = evt_q;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence s_pwr_moves;
      word[spss_pkg::B_POWERED] != $past(word[spss_pkg::B_POWERED]);
   endsequence

   chk_rsvd_zero: assert property (word[26:14] == 13'h0)
      else $error("reserved bits not zero");
   chk_five_volt_cap: assert property (word[28] == !dev_ctl_5v_off_i)
      else $error("5 V capability wrong");
   chk_detect_frozen: assert property ($past(interrog_busy_i) && !$past(ctx_clr)
      |-> $stable(word[2:1]))
      else $error("detect bits moved during interrogation");
   chk_ready_follow: assert property (##3 word[6] == $past(pins_i.card_ready_irq_pin, 2))
      else $error("ready bit not following pin");
   chk_type_hold: assert property (!interrog_done_i && !force_wr && !ctx_clr
      |=> $stable(word[5:4]))
      else $error("card type changed without interrogation");
   chk_status_read: assert property (rd_state |=> reg_rdata_o == $past(word))
      else $error("status read mismatch");
   chk_power_event: assert property (s_pwr_moves |-> evt_q[spss_pkg::E_PWR])
      else $error("power change not flagged");
   chk_ctx_clear: assert property (ctx_clr |=> word[13:7] == 7'h0 && word[5:3] == 3'h0)
      else $error("context bits not cleared");
   chk_unrec_hold: assert property (unrec_q && !ctx_clr && !(interrog_done_i
      && (interrog_res_i.is_32bit || interrog_res_i.is_16bit)) |=> unrec_q)
      else $error("unrecognised flag dropped early");
   chk_caps_force: assert property (!force_wr |=> $stable(word[31:29]))
      else $error("socket caps changed without force");
endmodule // spss_state

// [verification/spss_card_model.sv]
`timescale 1ns/10ps
// ****************************************
// card seated at the socket
// ****************************************
module spss_card_model (
   input wire logic [1:0] det_i,
   input wire logic irq_i,
   input wire logic sts_i,
   input wire logic bus_rst_n_i,
   output spss_pkg::spss_pins_t pins_o
);
   // detect lines read high with no card, low once seated
   assign pins_o.detect_pin_a = det_i[0];
   assign pins_o.detect_pin_b = det_i[1];
   // pure levels: no glitch filtering, the block must sync them
   assign pins_o.card_status_change_pin = sts_i;
   assign pins_o.card_ready_irq_pin = irq_i;
   assign pins_o.bus_reset_n = bus_rst_n_i;
endmodule // spss_card_model

// [verification/spss_state_tb_top.sv]
`timescale 1ns/10ps
module spss_state_tb_top;
   typedef struct packed {
      logic [3:0] in;
      logic [7:0] exp;
   } spss_row_t;
   logic mclk_i, rst_i, reg_rd_i, reg_wr_i, ctl5_i, wake_i, busy_i, done_i, pwr_i, bad_i, loss_i;
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, d;
   logic [3:0] event_flags_o;
   logic [1:0] det;
   logic irq, sts, brst_n;
   spss_pkg::spss_pins_t pins;
   spss_pkg::spss_interrog_t res;
   int error_cnt, total_checks;
   // {det_b, det_a, irq, sts} beside the low byte they give
   spss_row_t rows [6] = '{'{4'hc, 8'h06}, '{4'h4, 8'h02}, '{4'h8, 8'h04},
                           '{4'h2, 8'h40}, '{4'h1, 8'h01}, '{4'h0, 8'h00}};
   spss_card_model card (.det_i(det), .irq_i(irq), .sts_i(sts), .bus_rst_n_i(brst_n),
                         .pins_o(pins));
   spss_state dut (.mclk_i(mclk_i), .rst_i(rst_i), .pins_i(pins), .reg_rd_i(reg_rd_i),
      .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .dev_ctl_5v_off_i(ctl5_i), .power_mgmt_wake_i(wake_i),
      .interrog_busy_i(busy_i), .interrog_done_i(done_i), .interrog_res_i(res),
      .socket_powered_i(pwr_i), .bad_vcc_req_i(bad_i), .data_loss_i(loss_i),
      .event_flags_o(event_flags_o));
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(negedge mclk_i);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(negedge mclk_i);
      reg_rd_i = 1'b0;
      v = reg_rdata_o;
   endtask
   task automatic chkw(input string what, input logic [31:0] exp);
      logic [31:0] v;
      rd(8'h08, v);
      chk(what, exp, v);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(negedge mclk_i);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = v;
      @(negedge mclk_i);
      reg_wr_i = 1'b0;
      @(negedge mclk_i);
   endtask
   task automatic done(input logic [6:0] r);
      @(negedge mclk_i);
      res = r;
      done_i = 1'b1;
      @(negedge mclk_i);
      done_i = 1'b0;
      cyc(1);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ****************************************
   // clock, watchdog
   // ****************************************
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   initial begin
      repeat (100000) @(posedge mclk_i);
      error_cnt++;
      conclude();
   end
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      {rst_i, reg_rd_i, reg_wr_i, ctl5_i, wake_i, busy_i, done_i, pwr_i, bad_i, loss_i} = 10'h200;
      {reg_addr_i, reg_wdata_i, res, irq, sts} = '0;
      det = 2'h3;
      brst_n = 1'b1;
      cyc(16);
      rst_i = 1'b0;
      cyc(4);
      chkw("reset word", 32'h3000_0006);
      chk("reset flags", 32'h0, {28'h0, event_flags_o});
      $display("reset test done");
      foreach (rows[i]) begin
         {det, irq, sts} = rows[i].in;
         cyc(4);
         chkw("pin levels", 32'h3000_0000 | rows[i].exp);
      end
      $display("pin table done");
      // awkward cases: writes at the word, refused reads, overrides
      wr(8'h08, 32'hffff_ffff);
      chkw("after write", 32'h3000_0000);
      rd(8'h04, d);
      chk("mask read", 32'h0, d);
      ctl5_i = 1'b1;
      chkw("5v override", 32'h2000_0000);
      ctl5_i = 1'b0;
      wr(8'h0c, 32'hcfff_fc00);
      chkw("forced caps", 32'hd800_3c00);
      wr(8'h0c, 32'h2000_0000);
      chkw("caps back", 32'h3000_3c00);
      $display("override test done");
      wr(8'h00, 32'h0000_000f);
      {pwr_i, bad_i, loss_i} = 3'h7;
      cyc(1);
      {bad_i, loss_i} = 2'h0;
      cyc(2);
      chkw("flag bits", 32'h3000_3f08);
      chk("power event", 32'h8, {28'h0, event_flags_o});
      wr(8'h00, 32'h0000_0008);
      chk("event clear", 32'h0, {28'h0, event_flags_o});
      $display("status test done");
      busy_i = 1'b1;
      det = 2'h3;
      cyc(5);
      chkw("frozen detect", 32'h3000_3f08);
      done(7'h54);
      chkw("unrecognised", 32'h3000_2b88);
      done(7'h11);
      chkw("16-bit card", 32'h3000_0b18);
      busy_i = 1'b0;
      cyc(5);
      chkw("detect free", 32'h3000_0b1e);
      chk("detect events", 32'h6, {28'h0, event_flags_o});
      $display("interrogation test done");
      wake_i = 1'b1;
      brst_n = 1'b0;
      cyc(5);
      chkw("wake keeps", 32'h3000_0b1e);
      wake_i = 1'b0;
      cyc(5);
      chkw("bus reset clears", 32'h3000_0006);
      brst_n = 1'b1;
      $display("context test done");
      // cardbus card: status flag on rising edge only
      cyc(4);
      done(7'h02);
      wr(8'h00, 32'h0000_000f);
      sts = 1'b1;
      cyc(4);
      chk("cardbus rise", 32'h1, {28'h0, event_flags_o});
      wr(8'h00, 32'h0000_0001);
      sts = 1'b0;
      cyc(4);
      chk("cardbus fall", 32'h0, {28'h0, event_flags_o});
      chkw("cardbus type", 32'h3000_002e);
      wr(8'h0c, 32'h2000_0005);
      rd(8'h00, d);
      chk("event read", 32'h5, d);
      $display("cardbus test done");
      // global reset clears context bits even with wake enabled
      wr(8'h0c, 32'h2000_0300);
      chkw("forced flags", 32'h3000_032e);
      wake_i = 1'b1;
      rst_i = 1'b1;
      pwr_i = 1'b0;
      cyc(2);
      rst_i = 1'b0;
      chk("reset rdata", 32'h0, reg_rdata_o);
      chk("reset events", 32'h0, {28'h0, event_flags_o});
      chkw("global reset", 32'h3000_0006);
      wake_i = 1'b0;
      $display("global reset test done");
      conclude();
   end
endmodule // spss_state_tb_top
